// >>> common/gpib_port_pkg.sv
// Shared offsets, field positions, reset values and command codes for the data port block
package gpib_port_pkg;

    // ------------------------------------------------------------------
    // Host register offsets
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W                = 9;
    localparam logic [8:0]  OFFS_DATA_PORT        = 9'h111;
    localparam logic [8:0]  OFFS_EVENT_FIRST      = 9'h113;
    localparam logic [8:0]  OFFS_AUX_CMD          = 9'h11b;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int unsigned BYTE_W                = 8;
    localparam int unsigned STATUS_BITS           = 8;
    localparam int unsigned BIT_CMD_PASS          = 7;
    localparam int unsigned BIT_ADDR_PASS         = 6;
    localparam int unsigned BIT_DEV_TRIGGER       = 5;
    localparam int unsigned BIT_END_RX            = 4;
    localparam int unsigned OTHER_EVENTS          = 4;

    // ------------------------------------------------------------------
    // Reset values and auxiliary command codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE              = 8'h00;
    localparam logic [7:0]  RST_MASK              = 8'h00;
    localparam logic [7:0]  AUX_VALID             = 8'h0f;

    typedef logic [7:0] byte_t;

endpackage : gpib_port_pkg

// >>> core/event_flag_cell.sv
// One sticky status bit that clears on read and holds off events during a read
`timescale 1ns/1ns
module event_flag_cell (
    input  wire logic clk,        // Chip clock
    input  wire logic resetn,     // Synchronous reset, active low
    input  wire logic event_in,   // Set condition, one-cycle pulse
    input  wire logic reading,    // Host read of the status register in progress
    input  wire logic read_end,   // First cycle after the read cycle
    output logic      flag_q      // Sticky status bit
);

    logic pend_q;

    // ------------------------------------------------------------------
    // Flag and deferred event
    // ------------------------------------------------------------------
    // Events seen during a read are parked so the clear at read end cannot eat them
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (read_end) begin
            flag_q <= pend_q | event_in;
            pend_q <= 1'b0;
        end else if (reading) begin
            pend_q <= pend_q | event_in;
        end else begin
            flag_q <= flag_q | event_in;
        end
    end

    a_event_sets: assert property (@(posedge clk) disable iff (!resetn)
        event_in && !reading && !read_end |=> flag_q)
        else $error("event outside a read did not set the flag");
    a_read_stable: assert property (@(posedge clk) disable iff (!resetn)
        reading && !read_end |=> $stable(flag_q))
        else $error("flag changed during a status read");

endmodule : event_flag_cell

// >>> core/gpib_data_port.sv
// Byte data port and first event status/mask pair of the bus interface
//
// Functional notes
// - Hold ready-for-data false until byte removed
// - Bit 0 is DIO1, bit 7 is DIO8
// - Data in and out share one offset
// - Outgoing byte latched apart from incoming
// - Data-out write starts source handshake
// - Status read or reset clears all bits
// - Unmasked status condition raises interrupt request
// - Mask never blocks status bit updates
// - Event during status read set afterwards
// - Command pass-through flag on unknown commands
// - Undefined-primary flag set and clear conditions
// - Unaddressed addressed commands are simply ignored
// - Pass-through holds acceptor until valid command
// - Pass-through off: drop unknown commands silently
// - Address pass-through flag on secondary address
// - Address pass-through stalls handshake, address readable
// - Device trigger flag on trigger state entry
// - End received on EOI or string match
// - String match only when reception allowed
`timescale 1ns/1ns
module gpib_data_port
    import gpib_port_pkg::*;
#(
    parameter gpib_port_pkg::byte_t AUX_NONVALID = 8'h0e    // Non-valid auxiliary code
) (
    input  wire logic                        clk,           // Chip clock, 25 MHz
    input  wire logic                        resetn,        // Power-on reset, active low
    input  wire logic [gpib_port_pkg::ADDR_W-1:0] host_addr, // Host byte offset
    input  wire logic                        host_rd,       // Host read cycle, level
    input  wire logic                        host_wr,       // Host write, one-cycle pulse
    input  wire gpib_port_pkg::byte_t        host_wdata,    // Host write data
    output gpib_port_pkg::byte_t             host_rdata_q,  // Host read data
    input  wire logic                        dma_take,      // DMA removed the data-in byte
    input  wire logic                        rx_strobe,     // Data byte accepted (ACDS)
    input  wire gpib_port_pkg::byte_t        incoming_byte_bits, // Bus data, [0]=DIO1
    input  wire logic                        rx_eoi,        // EOI came with the byte
    input  wire logic                        listener_active, // Listener active state
    input  wire logic                        cmd_strobe,    // Command byte accepted (ACDS)
    input  wire gpib_port_pkg::byte_t        cmd_byte,      // Command byte, [0]=DIO1
    input  wire logic                        cmd_universal, // Universal command group
    input  wire logic                        cmd_addressed, // Addressed command group
    input  wire logic                        cmd_secondary, // Secondary command group
    input  wire logic                        cmd_talk_addr, // Talk address group
    input  wire logic                        cmd_listen_addr, // Listen address group
    input  wire logic                        cmd_defined,   // Command decoded by the chip
    input  wire logic                        talker_addressed,   // Talker addressed state
    input  wire logic                        listener_addressed, // Listener addressed state
    input  wire logic                        talker_primary,     // Talker primary addressed
    input  wire logic                        listener_primary,   // Listener primary addressed
    input  wire logic                        trigger_active, // Device trigger active state
    input  wire logic                        command_passthrough_on, // Aux config B bit 0
    input  wire logic                        addressing_mode_hi, // Address mode bit 1
    input  wire logic                        addressing_mode_lo, // Address mode bit 0
    input  wire logic                        eos_reception_allowed, // Aux config A bit 2
    input  wire gpib_port_pkg::byte_t        end_string_match_reg, // End-of-string byte
    input  wire logic [gpib_port_pkg::OTHER_EVENTS-1:0] other_events, // Events for bits 3..0
    output gpib_port_pkg::byte_t             outgoing_byte_bits_q, // Out byte, [0]=DIO1
    output logic                             source_start_q, // Start source handshake, pulse
    output logic                             rfd_hold_q,    // Keep ready-for-data false
    output logic                             accept_hold_q, // Hold acceptor in ACDS
    output gpib_port_pkg::byte_t             passthrough_read_reg_q, // Passed-through byte
    output logic                             undefined_primary_flag_q, // Undefined primary
    output gpib_port_pkg::byte_t             event_status_first_q, // Status bits
    output logic                             irq_q          // Interrupt request
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (STATUS_BITS != BYTE_W) begin : g_bad_width
        $error("status register must be one byte wide");
    end
    if (AUX_NONVALID == AUX_VALID) begin : g_bad_code
        $error("non-valid code must differ from valid code");
    end

    // ------------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------------
    logic  sel_data;
    logic  sel_status;
    logic  sel_aux;
    logic  data_rd;
    logic  data_rd_q;
    logic  data_rd_end;
    logic  status_rd;
    logic  status_rd_q;
    logic  status_rd_end;
    logic  data_wr;
    logic  mask_wr;
    logic  aux_valid_wr;
    logic  aux_nonvalid_wr;
    byte_t mask_q;
    byte_t data_in_q;
    byte_t status_set;
    byte_t status_flags;

    assign sel_data        = (host_addr == OFFS_DATA_PORT);
    assign sel_status      = (host_addr == OFFS_EVENT_FIRST);
    assign sel_aux         = (host_addr == OFFS_AUX_CMD);
    // Direction picks the register behind the shared offset
    assign data_rd         = host_rd && sel_data;
    assign data_wr         = host_wr && sel_data;
    assign status_rd       = host_rd && sel_status;
    assign mask_wr         = host_wr && sel_status;
    assign aux_valid_wr    = host_wr && sel_aux && (host_wdata == AUX_VALID);
    assign aux_nonvalid_wr = host_wr && sel_aux && (host_wdata == AUX_NONVALID);
    assign data_rd_end     = data_rd_q && !data_rd;
    assign status_rd_end   = status_rd_q && !status_rd;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_rd_q   <= 1'b0;
            status_rd_q <= 1'b0;
        end else begin
            data_rd_q   <= data_rd;
            status_rd_q <= status_rd;
        end
    end

    // Read data follows the register selected while the read lasts
    always_ff @(posedge clk) begin
        if (!resetn) begin
            host_rdata_q <= RST_BYTE;
        end else if (data_rd) begin
            host_rdata_q <= data_in_q;
        end else if (status_rd) begin
            host_rdata_q <= status_flags;
        end else if (host_rd && sel_aux) begin
            host_rdata_q <= passthrough_read_reg_q;
        end else if (host_rd) begin
            host_rdata_q <= RST_BYTE;
        end
    end

    // ------------------------------------------------------------------
    // Incoming data and ready-for-data hold
    // ------------------------------------------------------------------
    // Bit order is kept as wired: index 0 is DIO1, index 7 is DIO8
    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_in_q <= RST_BYTE;
        end else if (rx_strobe) begin
            data_in_q <= incoming_byte_bits;
        end
    end

    // A new byte wins over removal of the previous one
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rfd_hold_q <= 1'b0;
        end else if (rx_strobe) begin
            rfd_hold_q <= 1'b1;
        end else if (data_rd_end || dma_take) begin
            rfd_hold_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outgoing byte and source handshake start
    // ------------------------------------------------------------------
    // Own latch, so reading data-in never disturbs a pending output byte
    always_ff @(posedge clk) begin
        if (!resetn) begin
            outgoing_byte_bits_q <= RST_BYTE;
        end else if (data_wr) begin
            outgoing_byte_bits_q <= host_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            source_start_q <= 1'b0;
        end else begin
            source_start_q <= data_wr;
        end
    end

    // ------------------------------------------------------------------
    // Command and address pass-through
    // ------------------------------------------------------------------
    logic unknown_cmd;
    logic cpt_event;
    logic apt_event;
    logic udp_clear;
    logic cpt_hold_q;
    logic apt_hold_q;
    logic cpt_hold_d;
    logic apt_hold_d;

    // Addressed commands only count while addressed; others fall away
    assign unknown_cmd = (cmd_universal ||
                          (cmd_addressed && (talker_addressed || listener_addressed)))
                         && !cmd_defined;
    // No new command pass-through flag or hold when pass-through is off; address pass-through does not depend on it
    assign cpt_event   = cmd_strobe && command_passthrough_on &&
                         (unknown_cmd || (undefined_primary_flag_q && cmd_secondary));
    assign apt_event   = cmd_strobe && addressing_mode_hi && addressing_mode_lo &&
                         (talker_primary || listener_primary) && cmd_secondary;
    assign udp_clear   = (cmd_strobe && (((cmd_universal || cmd_addressed) && cmd_defined)
                         || cmd_talk_addr || cmd_listen_addr)) || !command_passthrough_on;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            undefined_primary_flag_q <= 1'b0;
        end else if (cmd_strobe && command_passthrough_on && unknown_cmd) begin
            undefined_primary_flag_q <= 1'b1;
        end else if (udp_clear) begin
            undefined_primary_flag_q <= 1'b0;
        end
    end

    always_comb begin
        cpt_hold_d = cpt_hold_q;
        apt_hold_d = apt_hold_q;
        if (cpt_event) begin
            cpt_hold_d = 1'b1;
        end else if (aux_valid_wr) begin
            cpt_hold_d = 1'b0;
        end
        if (apt_event) begin
            apt_hold_d = 1'b1;
        end else if (aux_valid_wr || aux_nonvalid_wr) begin
            apt_hold_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cpt_hold_q    <= 1'b0;
            apt_hold_q    <= 1'b0;
            accept_hold_q <= 1'b0;
        end else begin
            cpt_hold_q    <= cpt_hold_d;
            apt_hold_q    <= apt_hold_d;
            accept_hold_q <= cpt_hold_d || apt_hold_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            passthrough_read_reg_q <= RST_BYTE;
        end else if (cpt_event || apt_event) begin
            passthrough_read_reg_q <= cmd_byte;
        end
    end

    // ------------------------------------------------------------------
    // Status set conditions
    // ------------------------------------------------------------------
    logic trigger_q;
    logic eos_hit;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            trigger_q <= 1'b0;
        end else begin
            trigger_q <= trigger_active;
        end
    end

    assign eos_hit = eos_reception_allowed &&
                     (incoming_byte_bits == end_string_match_reg);

    always_comb begin
        status_set                  = {{(STATUS_BITS-OTHER_EVENTS){1'b0}}, other_events};
        status_set[BIT_CMD_PASS]    = cpt_event;
        status_set[BIT_ADDR_PASS]   = apt_event;
        status_set[BIT_DEV_TRIGGER] = trigger_active && !trigger_q;
        status_set[BIT_END_RX] = listener_active && rx_strobe && (rx_eoi || eos_hit);
    end

    // ------------------------------------------------------------------
    // Status flags, mask and interrupt
    // ------------------------------------------------------------------
    for (genvar i = 0; i < STATUS_BITS; i++) begin : g_flag
        event_flag_cell u_cell (
            .clk      (clk),
            .resetn   (resetn),
            .event_in (status_set[i]),
            .reading  (status_rd),
            .read_end (status_rd_end),
            .flag_q   (status_flags[i])
        );
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            event_status_first_q <= RST_BYTE;
        end else begin
            event_status_first_q <= status_flags;
        end
    end

    // Mask only gates the request; flags update regardless
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mask_q <= RST_MASK;
        end else if (mask_wr) begin
            mask_q <= host_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_flags & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence byte_arrives;
        rx_strobe;
    endsequence

    sequence byte_removed;
        data_rd_end || dma_take;
    endsequence

    a_rfd_hold_set: assert property (@(posedge clk) disable iff (!resetn)
        byte_arrives |=> rfd_hold_q)
        else $error("ready-for-data not held after byte");
    a_rfd_release: assert property (@(posedge clk) disable iff (!resetn)
        byte_removed ##0 !rx_strobe |=> !rfd_hold_q)
        else $error("ready-for-data hold not released");
    a_out_latch: assert property (@(posedge clk) disable iff (!resetn)
        data_wr |=> outgoing_byte_bits_q == $past(host_wdata) && source_start_q)
        else $error("outgoing byte or handshake start wrong");
    a_out_kept: assert property (@(posedge clk) disable iff (!resetn)
        data_rd && !data_wr |=> $stable(outgoing_byte_bits_q))
        else $error("data-in read disturbed outgoing byte");
    a_irq_follows: assert property (@(posedge clk) disable iff (!resetn)
        (|(status_set & mask_q)) && !status_rd && !status_rd_end && !mask_wr
        |=> ##1 irq_q)
        else $error("unmasked event raised no interrupt");
    a_cpt_stall: assert property (@(posedge clk) disable iff (!resetn)
        cpt_event || (cpt_hold_q && !aux_valid_wr) |=> accept_hold_q)
        else $error("acceptor released before valid command");
    a_cpt_off: assert property (@(posedge clk) disable iff (!resetn)
        !command_passthrough_on && !apt_event && !cpt_hold_q && !apt_hold_q
        |=> !accept_hold_q)
        else $error("handshake stalled with pass-through off");
    a_apt_stall: assert property (@(posedge clk) disable iff (!resetn)
        apt_event |=> apt_hold_q && passthrough_read_reg_q == $past(cmd_byte))
        else $error("address pass-through not held");
    a_end_rx: assert property (@(posedge clk) disable iff (!resetn)
        listener_active && rx_strobe && rx_eoi && !status_rd && !status_rd_end
        |=> status_flags[BIT_END_RX])
        else $error("end received not flagged");
    // Single-cycle read only: a longer read may park earlier events that then set the flags at read end
    a_status_clear: assert property (@(posedge clk) disable iff (!resetn)
        !status_rd ##1 status_rd ##1 (!status_rd && status_set == RST_BYTE)
        ##0 $past(status_set) == RST_BYTE |=> status_flags == RST_BYTE)
        else $error("status read did not clear flags");
    a_udp_clear: assert property (@(posedge clk) disable iff (!resetn)
        !command_passthrough_on |=> !undefined_primary_flag_q)
        else $error("undefined primary flag kept with pass-through off");

endmodule : gpib_data_port

// >>> bench/gpib_bus_model.sv
// Bus-side talker and controller model feeding data and command bytes
`timescale 1ns/1ns
module gpib_bus_model
    import gpib_port_pkg::*;
(
    input  wire logic  clk,     // Chip clock
    input  wire logic  rfd_q,   // Ready-for-data held false
    input  wire logic  acc_q,   // Acceptor held in accept state
    output logic       rx_stb,  // Data byte strobe
    output gpib_port_pkg::byte_t rx_b, // Data byte
    output logic       rx_eoi,  // End with byte
    output logic       c_stb,   // Command strobe
    output gpib_port_pkg::byte_t c_b, // Command byte
    output logic [5:0] c_g      // Group: uni, addr, sec, talk, listen, defined
);
    import gpib_port_pkg::*;
    initial begin
        {rx_stb, rx_b, rx_eoi, c_stb, c_b, c_g} = '0;
    end
    // Waits up to 40 cycles while the port still refuses; released lines show inverted data
    task send_data(input byte_t d, input logic e);
        for (int i = 0; i < 40 && rfd_q !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        rx_stb <= 1'b1;
        rx_b <= d;
        rx_eoi <= e;
        @(posedge clk);
        rx_stb <= 1'b0;
        rx_b <= ~d;
        rx_eoi <= ~e;
        #1;
    endtask : send_data
    task send_cmd(input byte_t c, input logic [5:0] g);
        for (int i = 0; i < 40 && acc_q !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        c_stb <= 1'b1;
        c_b <= c;
        c_g <= g;
        @(posedge clk);
        c_stb <= 1'b0;
        c_b <= ~c;
        c_g <= ~g;
        #1;
    endtask : send_cmd
endmodule : gpib_bus_model

// >>> bench/testbench.sv
// Self-checking bench for the data port and first status/mask pair
`timescale 1ns/1ns
module testbench;
    import gpib_port_pkg::*;
    logic clk, resetn, hrd, hwr, dma, pt, eos, rs, re, cs;
    logic [8:0] ha;
    byte_t wd, rdq, ob, ptr, stq, eb, rb, cb;
    logic [7:0] st;
    logic [5:0] cg;
    logic src, rfd, acc, udp, irq;
    int err_total, compares, cyc;
    wire [7:0] hs = {rfd, acc, udp, irq, src, 3'h0};
    gpib_data_port u_gpib_data_port (.clk(clk), .resetn(resetn), .host_addr(ha),
        .host_rd(hrd), .host_wr(hwr), .host_wdata(wd), .host_rdata_q(rdq),
        .dma_take(dma), .rx_strobe(rs), .incoming_byte_bits(rb), .rx_eoi(re),
        .listener_active(st[7]), .cmd_strobe(cs), .cmd_byte(cb),
        .cmd_universal(cg[5]), .cmd_addressed(cg[4]), .cmd_secondary(cg[3]),
        .cmd_talk_addr(cg[2]), .cmd_listen_addr(cg[1]), .cmd_defined(cg[0]),
        .talker_addressed(st[6]), .listener_addressed(st[5]), .talker_primary(st[4]),
        .listener_primary(st[3]), .trigger_active(st[2]), .command_passthrough_on(pt),
        .addressing_mode_hi(st[1]), .addressing_mode_lo(st[0]),
        .eos_reception_allowed(eos), .end_string_match_reg(eb), .other_events(4'h0),
        .outgoing_byte_bits_q(ob), .source_start_q(src), .rfd_hold_q(rfd),
        .accept_hold_q(acc), .passthrough_read_reg_q(ptr),
        .undefined_primary_flag_q(udp), .event_status_first_q(stq), .irq_q(irq));
    gpib_bus_model u_gpib_bus_model (.clk(clk), .rfd_q(rfd), .acc_q(acc), .rx_stb(rs),
        .rx_b(rb), .rx_eoi(re), .c_stb(cs), .c_b(cb), .c_g(cg));
    // ------------------------------------------------------------------
    // Clock, timeout and host access tasks
    // ------------------------------------------------------------------
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            wrap_up();
        end
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [8:0] a, input byte_t d);
        @(posedge clk);
        ha <= a;
        wd <= d;
        hwr <= 1'b1;
        @(posedge clk);
        hwr <= 1'b0;
        #1;
    endtask : wr
    // Read data is checked after the sampling edge; clear happens at the next edge
    task rd(input logic [8:0] a, input byte_t e);
        @(posedge clk);
        ha <= a;
        hrd <= 1'b1;
        @(posedge clk);
        hrd <= 1'b0;
        #1;
        chk(rdq, e);
    endtask : rd
    task wrap_up;
        $display("Comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    initial begin
        {clk, resetn, hrd, hwr, dma, pt, eos, ha, wd, st, eb} = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(9'h113, 8'h00);
        wr(9'h111, 8'ha5);
        chk(ob, 8'ha5);
        chk(hs, 8'h08);
        st <= 8'h80;
        u_gpib_bus_model.send_data(8'h3c, 1'b0);
        chk(hs, 8'h80);
        rd(9'h111, 8'h3c);
        repeat (2) @(posedge clk);
        chk({hs[7], ob[6:0]}, 8'h25);
        eb <= 8'h0d;
        u_gpib_bus_model.send_data(8'h0d, 1'b0);
        dma <= 1'b1;
        @(posedge clk);
        dma <= 1'b0;
        rd(9'h113, 8'h00);
        eos <= 1'b1;
        u_gpib_bus_model.send_data(8'h0d, 1'b0);
        repeat (2) @(posedge clk);
        chk(hs, 8'h80);
        chk(stq, 8'h10);
        rd(9'h113, 8'h10);
        wr(9'h113, 8'h10);
        rd(9'h111, 8'h0d);
        u_gpib_bus_model.send_data(8'h55, 1'b1);
        repeat (2) @(posedge clk);
        chk(hs, 8'h90);
        rd(9'h113, 8'h10);
        repeat (3) @(posedge clk);
        chk(hs[4], 1'b0);
        st <= 8'h00;
        u_gpib_bus_model.send_cmd(8'h15, 6'h20);
        chk(hs[6:5], 2'h0);
        pt <= 1'b1;
        u_gpib_bus_model.send_cmd(8'h05, 6'h10);
        chk(hs[6:5], 2'h0);
        rd(9'h113, 8'h00);
        u_gpib_bus_model.send_cmd(8'h15, 6'h20);
        chk(hs[6:5], 2'h3);
        chk(ptr, 8'h15);
        wr(9'h11b, 8'h0f);
        u_gpib_bus_model.send_cmd(8'h61, 6'h08);
        rd(9'h113, 8'h80);
        wr(9'h11b, 8'h0f);
        u_gpib_bus_model.send_cmd(8'h14, 6'h21);
        chk(hs[6:5], 2'h0);
        pt <= 1'b0;
        st <= 8'h13;
        u_gpib_bus_model.send_cmd(8'h62, 6'h08);
        chk({hs[6], ptr[6:0]}, 8'he2);
        rd(9'h113, 8'h40);
        wr(9'h11b, 8'h0e);
        chk(hs[6], 1'b0);
        st <= 8'h04;
        repeat (2) @(posedge clk);
        rd(9'h113, 8'h20);
        st <= 8'h00;
        @(posedge clk);
        ha <= 9'h113;
        hrd <= 1'b1;
        st <= 8'h04;
        repeat (2) @(posedge clk);
        hrd <= 1'b0;
        rd(9'h113, 8'h20);
        wrap_up();
    end
endmodule : testbench
